/* hw/fhl_defines.svh */
`ifndef FHL_DEFINES_SVH
`define FHL_DEFINES_SVH
`define FHL_IDX_HIST_A 12'he46
`define FHL_IDX_HIST_B 12'he47
`define FHL_IDX_HIST_C 12'he48
`define FHL_IDX_HIST_D 12'he49
`define FHL_IDX_SNAP_FREQ 12'he32
`define FHL_IDX_SNAP_VBUS 12'he33
`define FHL_IDX_SNAP_CURR 12'he34
`define FHL_IDX_SNAP_TEMP 12'he35
`define FHL_IDX_BASIC_LOG 12'he50
`define FHL_IDX_CTRL 12'he51
`define FHL_IDX_IRQ_STAT 12'he52
`define FHL_IDX_IRQ_MASK 12'he53
`define FHL_CTRL_CLR_STOP 0
`define FHL_CTRL_DEB_EN 1
`define FHL_IRQ_LOGGED 0
`define FHL_IRQ_DROPPED 1
`define FHL_RESET_VAL 16'h0000
`define FHL_CODE_POWER_LOSS 16'h003e
`define FHL_CODE_UV_STOP 16'h000e
`endif

/* hw/fhl_pkg.sv */
`default_nettype none
package fhl_pkg;
  typedef logic [15:0] fhl_word_t;
  typedef struct packed {
    fhl_word_t freq;
    fhl_word_t vbus;
    fhl_word_t curr;
    fhl_word_t temp;
  } fhl_snap_s;
  typedef struct packed {
    logic valid;
    fhl_word_t code;
  } fhl_fault_s;
endpackage
`default_nettype wire

/* hw/fhl_top.sv */
// Design decision made here: the Wishbone slave port.
`include "fhl_defines.svh"
`default_nettype none
module fhl_top import fhl_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fault_valid_i,
  input wire logic [15:0] fault_code_i,
  input wire logic power_loss_decel_i,
  input wire fhl_snap_s live_i,
  output logic drive_stop_o,
  output logic irq_o
);
  typedef struct packed {
    fhl_word_t [3:0] hist;
    fhl_snap_s snap;
    fhl_word_t basic;
    logic stop;
    logic deb_en;
    logic [1:0] stat;
    logic [1:0] mask;
    logic ack;
    logic [31:0] rdat;
  } fhl_state_s;

  fhl_state_s s_q, s_d;

  // Full table of legal codes
  function automatic logic code_defined(input fhl_word_t c);
    unique case (c)
      16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0006: return 1'b1;
      16'h0007, 16'h0008, 16'h0009, 16'h000a: return 1'b1;
      16'h000b, 16'h000c, 16'h000d, 16'h000e: return 1'b1;
      16'h000f, 16'h0010, 16'h0012: return 1'b1;
      16'h0015, 16'h0016, 16'h0017, 16'h0018: return 1'b1;
      16'h001a, 16'h001b, 16'h001c: return 1'b1;
      16'h001f, 16'h0021, 16'h0022, 16'h0023: return 1'b1;
      16'h0024, 16'h0025: return 1'b1;
      16'h0028, 16'h0029, 16'h0030, 16'h0031: return 1'b1;
      16'h0032, 16'h0033, 16'h0034: return 1'b1;
      16'h0036, 16'h0037, 16'h0038, 16'h0039: return 1'b1;
      16'h003a: return 1'b1;
      16'h003f, 16'h0052, 16'h0053, 16'h0054: return 1'b1;
      16'h0057: return 1'b1;
      16'h008e, 16'h008f, 16'h0095, 16'h0096: return 1'b1;
      16'h0097, 16'h0098, 16'h009d: return 1'b1;
      16'h003e: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic req;
  logic [11:0] idx;
  logic fault_ok;
  logic log_now;
  fhl_word_t log_code;
  logic deb_act;

  assign deb_act = power_loss_decel_i & s_q.deb_en;

  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign idx = wb_adr_i[13:2];
  // Stopped undervoltage never logged
  assign fault_ok = fault_valid_i & code_defined(fault_code_i)
                    & (fault_code_i != `FHL_CODE_UV_STOP);
  assign log_now = fault_ok | (power_loss_decel_i & s_q.deb_en);
  assign log_code = (power_loss_decel_i & s_q.deb_en) ?
                    `FHL_CODE_POWER_LOSS : fault_code_i;

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.rdat = 32'h0000_0000;
    if (log_now) begin
      s_d.hist[3] = s_q.hist[2];
      s_d.hist[2] = s_q.hist[1];
      s_d.hist[1] = s_q.hist[0];
      s_d.hist[0] = log_code;
      s_d.snap = live_i;
      s_d.basic = log_code;
      s_d.stop = 1'b1;
    end
    if (req && wb_we_i && idx == `FHL_IDX_CTRL) begin
      if (wb_sel_i[0]) begin
        s_d.deb_en = wb_dat_i[`FHL_CTRL_DEB_EN];
        if (wb_dat_i[`FHL_CTRL_CLR_STOP] && !log_now)
          s_d.stop = 1'b0;
      end
    end
    if (req && wb_we_i && idx == `FHL_IDX_IRQ_MASK && wb_sel_i[0])
      s_d.mask = wb_dat_i[1:0];
    if (req && !wb_we_i) begin
      if (idx >= `FHL_IDX_HIST_A && idx <= `FHL_IDX_HIST_D)
        s_d.rdat[15:0] = s_q.hist[2'(idx - `FHL_IDX_HIST_A)];
      else if (idx == `FHL_IDX_SNAP_FREQ)
        s_d.rdat[15:0] = s_q.snap.freq;
      else if (idx == `FHL_IDX_SNAP_VBUS)
        s_d.rdat[15:0] = s_q.snap.vbus;
      else if (idx == `FHL_IDX_SNAP_CURR)
        s_d.rdat[15:0] = s_q.snap.curr;
      else if (idx == `FHL_IDX_SNAP_TEMP)
        s_d.rdat[15:0] = s_q.snap.temp;
      else if (idx == `FHL_IDX_BASIC_LOG)
        s_d.rdat[15:0] = s_q.basic;
      else if (idx == `FHL_IDX_CTRL)
        s_d.rdat[1:0] = {s_q.deb_en, s_q.stop};
      else if (idx == `FHL_IDX_IRQ_STAT)
        s_d.rdat[1:0] = s_q.stat;
      else if (idx == `FHL_IDX_IRQ_MASK)
        s_d.rdat[1:0] = s_q.mask;
    end
    // Read clears status, new event wins
    if (req && !wb_we_i && idx == `FHL_IDX_IRQ_STAT)
      s_d.stat = 2'b00;
    if (log_now)
      s_d.stat[`FHL_IRQ_LOGGED] = 1'b1;
    if (fault_valid_i && !fault_ok)
      s_d.stat[`FHL_IRQ_DROPPED] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign drive_stop_o = s_q.stop;
  assign irq_o = |(s_q.stat & s_q.mask);

  chk_hist_reset_zero: assert property (@(posedge clk_i)
    $past(rst_i) |-> s_q.hist[0] == `FHL_RESET_VAL)
    else $error("history not zero after reset");
  chk_log_sets_head: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_ok && !(power_loss_decel_i && s_q.deb_en) |=>
    s_q.hist[0] == $past(fault_code_i))
    else $error("logged code missing in head slot");
  chk_log_forces_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> drive_stop_o)
    else $error("stop not forced by fault");
  chk_uv_stop_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == `FHL_CODE_UV_STOP &&
    !power_loss_decel_i |=> $stable(s_q.hist))
    else $error("stopped undervoltage was logged");
  chk_uv_run_log: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h000c && !power_loss_decel_i
    |=> s_q.hist[0] == 16'h000c)
    else $error("running undervoltage not logged");
  chk_deb_both_logs: assert property (@(posedge clk_i) disable iff (rst_i)
    power_loss_decel_i && s_q.deb_en |=> s_q.hist[0] == 16'h003e
    && s_q.basic == 16'h003e)
    else $error("power loss code not in both logs");
  chk_snap_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> s_q.snap == $past(live_i))
    else $error("snapshot not captured");
  chk_shift_order: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> s_q.hist[3] == $past(s_q.hist[2]) &&
    s_q.hist[1] == $past(s_q.hist[0]))
    else $error("history did not shift");
  chk_codes_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.hist[0] == 16'h0000 || code_defined(s_q.hist[0]))
    else $error("undefined code in history");
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");

  // Bus handshake steps
  sequence seq_bus_take;
    req;
  endsequence
  sequence seq_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_bus_handshake: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_bus_take |=> seq_bus_answer)
    else $error("bus answer not a single ack");
  chk_dat_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero while idle");

  // Read-back and hold of the history records
  chk_read_hist_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_HIST_A
    |=> wb_dat_o == {16'h0000, $past(s_q.hist[0])})
    else $error("first record read wrong");
  chk_read_hist_b: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_HIST_B
    |=> wb_dat_o == {16'h0000, $past(s_q.hist[1])})
    else $error("second record read wrong");
  chk_read_hist_c: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_HIST_C
    |=> wb_dat_o == {16'h0000, $past(s_q.hist[2])})
    else $error("third record read wrong");
  chk_read_hist_d: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_HIST_D
    |=> wb_dat_o == {16'h0000, $past(s_q.hist[3])})
    else $error("fourth record read wrong");
  chk_ro_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && idx >= `FHL_IDX_HIST_A && idx <= `FHL_IDX_HIST_D &&
    !log_now |=> $stable(s_q.hist))
    else $error("write changed a history record");
  chk_hist_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !log_now |=> $stable(s_q.hist))
    else $error("history changed without a fault");

  // Snapshot reads and hold
  chk_read_snap_freq: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_SNAP_FREQ
    |=> wb_dat_o[15:0] == $past(s_q.snap.freq))
    else $error("frequency snapshot read wrong");
  chk_read_snap_vbus: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_SNAP_VBUS
    |=> wb_dat_o[15:0] == $past(s_q.snap.vbus))
    else $error("bus voltage snapshot read wrong");
  chk_read_snap_curr: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_SNAP_CURR
    |=> wb_dat_o[15:0] == $past(s_q.snap.curr))
    else $error("current snapshot read wrong");
  chk_snap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !log_now |=> $stable(s_q.snap))
    else $error("snapshot changed without a fault");

  // Stop, control, status and logging behaviour
  chk_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.stop && !(req && wb_we_i && idx == `FHL_IDX_CTRL && wb_sel_i[0] &&
    wb_dat_i[`FHL_CTRL_CLR_STOP]) |=> drive_stop_o)
    else $error("stop released without a clear");
  chk_stop_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && idx == `FHL_IDX_CTRL && wb_sel_i[0] &&
    wb_dat_i[`FHL_CTRL_CLR_STOP] && !log_now |=> !drive_stop_o)
    else $error("stop not cleared by control write");
  chk_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && idx == `FHL_IDX_IRQ_MASK && wb_sel_i[0]
    |=> s_q.mask == $past(wb_dat_i[1:0]))
    else $error("mask write not taken");
  chk_stat_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_IRQ_STAT
    |=> wb_dat_o[1:0] == $past(s_q.stat))
    else $error("status read wrong");
  chk_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == `FHL_IDX_IRQ_STAT && !log_now &&
    !fault_valid_i |=> s_q.stat == 2'b00)
    else $error("status not cleared by read");
  chk_stat_logged: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> s_q.stat[`FHL_IRQ_LOGGED])
    else $error("logged flag not set");
  chk_stat_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && !fault_ok |=> s_q.stat[`FHL_IRQ_DROPPED])
    else $error("dropped flag not set");
  chk_undef_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && !code_defined(fault_code_i) && !deb_act
    |=> $stable(s_q.hist))
    else $error("undefined code was logged");
  chk_head_defined: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> code_defined(s_q.hist[0]))
    else $error("logged head code undefined");
  chk_basic_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> s_q.basic == s_q.hist[0])
    else $error("basic log differs from history");
  chk_shift_middle: assert property (@(posedge clk_i) disable iff (rst_i)
    log_now |=> s_q.hist[2] == $past(s_q.hist[1]))
    else $error("middle slot did not shift");

  // Spot checks of the code table
  chk_code_oc_accel: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0001 && !deb_act
    |=> s_q.hist[0] == 16'h0001)
    else $error("overcurrent code not logged");
  chk_code_ground: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0004 && !deb_act
    |=> s_q.hist[0] == 16'h0004)
    else $error("ground fault code not logged");
  chk_code_ov_accel: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0007 && !deb_act
    |=> s_q.hist[0] == 16'h0007)
    else $error("overvoltage code not logged");
  chk_code_uv_accel: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h000b && !deb_act
    |=> s_q.hist[0] == 16'h000b)
    else $error("undervoltage code not logged");
  chk_code_sense: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0012 && !deb_act
    |=> s_q.hist[0] == 16'h0012)
    else $error("sensor fail code not logged");
  chk_code_relay: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0016 && !deb_act
    |=> s_q.hist[0] == 16'h0016)
    else $error("thermal relay code not logged");
  chk_code_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0024 && !deb_act
    |=> s_q.hist[0] == 16'h0024)
    else $error("clamp error code not logged");
  chk_code_block: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0033 && !deb_act
    |=> s_q.hist[0] == 16'h0033)
    else $error("external block code not logged");
  chk_code_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0039 && !deb_act
    |=> s_q.hist[0] == 16'h0039)
    else $error("read-only write code not logged");
  chk_code_out_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h0052 && !deb_act
    |=> s_q.hist[0] == 16'h0052)
    else $error("output phase code not logged");
  chk_code_pump: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_valid_i && fault_code_i == 16'h009d && !deb_act
    |=> s_q.hist[0] == 16'h009d)
    else $error("pump feedback code not logged");
endmodule
`default_nettype wire

/* verification/fhl_fault_src.sv */
`default_nettype none
module fhl_fault_src (
  input wire logic clk_i,
  output logic valid_o = 1'b0,
  output logic [15:0] code_o = 16'h0000,
  output logic decel_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle event; code scrambled once the pulse is over
  task automatic fire(input logic [15:0] c, input logic pl);
    @(posedge clk_i);
    valid_o <= ~pl;
    decel_o <= pl;
    code_o <= c;
    @(posedge clk_i);
    valid_o <= 1'b0;
    decel_o <= 1'b0;
    code_o <= ~c;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
module testbench import fhl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [13:0] adr = 14'h0000;
  logic [31:0] wdat = 32'h0, rdat, dat;
  logic ack, stop, irq, fv, pl;
  logic [15:0] fc;
  fhl_snap_s live = {16'h0101, 16'h0202, 16'h0303, 16'h0404};
  int n_errors = 0, comparisons = 0;
  int codes[] = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 15, 16, 18,
    21, 22, 23, 24, 26, 27, 28, 31, 33, 34, 35, 36, 37, 40, 41, 48,
    49, 50, 51, 52, 54, 55, 56, 57, 58, 63, 82, 83, 84, 87, 142, 143,
    149, 150, 151, 152, 157};
  fhl_top fhl_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .fault_valid_i(fv), .fault_code_i(fc), .power_loss_decel_i(pl),
    .live_i(live), .drive_stop_o(stop), .irq_o(irq));
  fhl_fault_src fhl_fault_src_i (.clk_i(clk_i), .valid_o(fv),
    .code_o(fc), .decel_o(pl));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] i,
                     input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      test_done();
    end
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), e, rdat);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd(12'he46 + 12'(i), 0);
    bus(1'b1, 12'he47, 32'hffff);
    rd(12'he47, 0);
    rd(12'h7ff, 0);
    chk("irq", 0, irq);
    $display("reset test done");
    bus(1'b1, 12'he53, 32'h3);
    foreach (codes[n]) begin
      fhl_fault_src_i.fire(16'(codes[n]), 1'b0);
      rd(12'he46, codes[n]);
      chk("stop", 1, stop);
    end
    rd(12'he47, 152);
    rd(12'he49, 150);
    rd(12'he32, live.freq);
    chk("irq", 1, irq);
    rd(12'he52, 1);
    chk("irq", 0, irq);
    $display("code test done");
    bus(1'b1, 12'he51, 32'h1);
    fhl_fault_src_i.fire(16'd14, 1'b0);
    fhl_fault_src_i.fire(16'd5, 1'b0);
    rd(12'he46, 157);
    chk("stop", 0, stop);
    rd(12'he52, 2);
    $display("drop test done");
    bus(1'b1, 12'he51, 32'h2);
    live <= {16'h1111, 16'h2222, 16'h3333, 16'h4444};
    fhl_fault_src_i.fire(16'd1, 1'b1);
    rd(12'he33, 32'h2222);
    rd(12'he35, 32'h4444);
    rd(12'he51, 32'h3);
    rd(12'he46, 62);
    rd(12'he50, 62);
    rd(12'he47, 157);
    $display("power loss test done");
    test_done();
  end
endmodule
`default_nettype wire
